// [pkg/sarrd_pkg.sv]
// Constants shared by the converter end and the host end of the serial readout.
// Assumes one 10 MHz system clock per end; link pins are sampled, never clocked on.
//
// Summary of operation
// - Trigger rise samples SDI: high chip-select, low chain
// - SDI tied high selects 3-wire chip-select
// - Host waits max conversion time without busy
// - Busy bit on SDO; host flushes one extra clock
// - Chip-select busy if trigger or SDI low at end
// - Chain busy enabled when SCLK high at trigger rise
// - Host keeps SCLK, SDI quiet around trigger rise
// - Host digital activity after conversion or early half
// - SDO valid both edges; host captures on falling
// - Trigger fall with SCLK high enters shutdown
// - Trigger fall with SCLK low leaves shutdown
// - Chip-select trigger rise converts, releases SDO
// - Conversion completes regardless of trigger level
// - No-busy host returns trigger high before min time
// - Trigger low shows MSB; SCLK falls shift next
// - No-busy release SDO after 16th fall or trigger high
// - Busy host returns trigger low before min time
// - Busy mode drives SDO low at conversion end
// - Busy mode releases SDO after 17th fall
// - Four-wire: SDI low after conversion shows MSB; code keeps SDO released while trigger high
// - Chain needs sixteen falls per converter
package sarrd_pkg;
    localparam int SARRD_DATA_W = 16;
    localparam int SARRD_CLK_NS = 100;
    // Conversion window of the device
    localparam int SARRD_TCONV_MIN_NS = 1500;
    localparam int SARRD_TCONV_MAX_NS = 2000;
    localparam int SARRD_CONV_CYC = (SARRD_TCONV_MAX_NS + SARRD_CLK_NS - 1) / SARRD_CLK_NS;
    // Quiet time around a trigger rise
    localparam int SARRD_QUIET_PRE_NS = 25;
    localparam int SARRD_QUIET_POST_NS = 10;
    localparam int SARRD_QUIET_CYC = (SARRD_QUIET_PRE_NS + SARRD_CLK_NS - 1) / SARRD_CLK_NS;
    // Host link clock half period, in system cycles
    // Twice this, one full period, covers both synchronisers and the output register
    localparam int SARRD_SCK_HALF_CYC = 8;
    localparam logic [15:0] SARRD_RESULT_RST = 16'h0000;
    // Host register offsets
    localparam logic [3:0] SARRD_REG_CTRL = 4'h0;
    localparam logic [3:0] SARRD_REG_STAT = 4'h1;
    localparam logic [3:0] SARRD_REG_DATA = 4'h2;
    localparam int SARRD_CTRL_GO = 0;
    localparam int SARRD_CTRL_BUSY = 1;
    localparam int SARRD_CTRL_SHDN = 2;
    localparam int SARRD_CTRL_WAKE = 3;
    typedef enum logic [1:0] {SARRD_MODE_CS, SARRD_MODE_CHAIN} sarrd_mode_t;
endpackage

// [pkg/sarrd_if.sv]
// Link wires between converter end and host end.
// Assumes the host end resolves SDO from its data and enable.
`timescale 1ns/10ps
`default_nettype none
interface sarrd_if;
    logic conversion_trigger;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    modport dev (input conversion_trigger, input sclk, input sdi, output sdo, output sdo_oe);
    modport host (output conversion_trigger, output sclk, output sdi, input sdo, input sdo_oe);
endinterface
`default_nettype wire

// [hdl/sarrd_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input.
`timescale 1ns/10ps
`default_nettype none
module sarrd_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic d_i,
    output logic q_o
);
    logic [2:0] s_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Reset to the pin's idle level so no false edge follows reset
            s_r <= {3{RST_VAL}};
        end else begin
            s_r <= {s_r[1:0], d_i};
        end
    end
    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= RST_VAL;
        end else if (s_r[1] == s_r[2]) begin
            q_o <= s_r[2];
        end
    end
endmodule
`default_nettype wire

// [hdl/sarrd_dev.sv]
// Converter end: mode pick, internal conversion timer, shift-out, shutdown.
// Assumes link pins from another domain; result word is given on a port.
`timescale 1ns/10ps
`default_nettype none
module sarrd_dev
    import sarrd_pkg::*;
#(
    parameter int DATA_W = SARRD_DATA_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    sarrd_if.dev link,
    input wire logic [DATA_W-1:0] sample_i,
    output logic converting_o,
    output logic shutdown_o,
    output logic chain_mode_o,
    output logic busy_en_o
);
    localparam int CNT_W = $clog2(SARRD_CONV_CYC + 1);
    typedef enum logic [1:0] {SARRD_ACQ, SARRD_CONV, SARRD_READ} sarrd_dstate_t;
    sarrd_dstate_t st_r;
    logic trg, sck, sdi, trg_d_r, sck_d_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DATA_W:0] sh_r;
    logic [5:0] nfall_r;
    logic sdo_r, oe_r;
    // Trigger idles high
    sarrd_sync #(.RST_VAL(1'b1)) u_trg (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(link.conversion_trigger), .q_o(trg));
    sarrd_sync u_sck (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sclk), .q_o(sck));
    sarrd_sync u_sdi (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sdi), .q_o(sdi));
    wire trg_rise = trg & ~trg_d_r;
    wire trg_fall = ~trg & trg_d_r;
    wire sck_fall = ~sck & sck_d_r;
    wire conv_done = (st_r == SARRD_CONV) && (cnt_r == CNT_W'(SARRD_CONV_CYC - 1));
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trg_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            trg_d_r <= trg;
            sck_d_r <= sck;
        end
    end
    // ==========================================================
    // Shutdown
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shutdown_o <= 1'b0;
        end else if (trg_fall && st_r != SARRD_CONV) begin
            shutdown_o <= sck;
        end
    end
    // ==========================================================
    // Mode and busy selection
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chain_mode_o <= 1'b0;
            busy_en_o <= 1'b0;
        end else if (trg_rise && st_r != SARRD_CONV && !shutdown_o) begin
            chain_mode_o <= ~sdi;
            busy_en_o <= ~sdi & sck;
        end else if (conv_done && !chain_mode_o) begin
            busy_en_o <= ~trg | ~sdi;
        end
    end
    // ==========================================================
    // Conversion timer; runs on whatever the trigger does
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= SARRD_ACQ;
            cnt_r <= '0;
        end else begin
            case (st_r)
                SARRD_ACQ, SARRD_READ: begin
                    cnt_r <= '0;
                    if (trg_rise && !shutdown_o) begin
                        st_r <= SARRD_CONV;
                    end
                end
                SARRD_CONV: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (conv_done) begin
                        st_r <= SARRD_READ;
                    end
                end
                default: st_r <= SARRD_ACQ;
            endcase
        end
    end
    assign converting_o = (st_r == SARRD_CONV);
    // ==========================================================
    // Shift register and SDO
    // Busy bit sits above the data so one extra fall flushes it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_r <= '0;
            nfall_r <= 6'h0;
        end else if (conv_done) begin
            sh_r <= {1'b0, sample_i};
            nfall_r <= 6'h0;
        end else if (st_r == SARRD_READ && sck_fall) begin
            sh_r <= {sh_r[DATA_W-1:0], sdi};
            nfall_r <= nfall_r + 6'h1;
        end
    end
    wire [5:0] last_fall = busy_en_o ? 6'(DATA_W + 1) : 6'(DATA_W);
    wire sel = chain_mode_o ? 1'b1 : (busy_en_o ? 1'b1 : ~trg);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_r <= 1'b0;
            sdo_r <= 1'b0;
        end else if (chain_mode_o) begin
            oe_r <= 1'b1;
            sdo_r <= (st_r == SARRD_READ) ? (busy_en_o ? sh_r[DATA_W] : sh_r[DATA_W-1])
                                          : (~trg & ~sdi);
        end else if (st_r == SARRD_CONV || (trg_rise && !shutdown_o)) begin
            oe_r <= conv_done & busy_en_o;
            sdo_r <= 1'b0;
        end else if (st_r == SARRD_READ && sel && trg_d_r == trg && !(busy_en_o && trg)) begin
            oe_r <= (nfall_r < last_fall);
            sdo_r <= busy_en_o ? sh_r[DATA_W] : sh_r[DATA_W-1];
        end else begin
            oe_r <= ~trg & ~sdi & ~(st_r == SARRD_READ);
            sdo_r <= 1'b0;
        end
    end
    assign link.sdo = sdo_r;
    assign link.sdo_oe = oe_r;
endmodule
`default_nettype wire

// [hdl/sarrd_host.sv]
// Host end: 3-wire chip-select readout with optional busy flush.
// Assumes a plain register port; SDO is gated by its enable here, before the synchroniser.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sarrd_host
    import sarrd_pkg::*;
#(
    parameter int DATA_W = SARRD_DATA_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    sarrd_if.host link,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o
);
    typedef enum logic [2:0] {H_IDLE, H_CONV, H_WAITB, H_SHIFT, H_PWR} sarrd_hstate_t;
    sarrd_hstate_t st_r;
    logic busy_mode_r, pwr_sck_r, done_r;
    logic [7:0] cnt_r;
    logic [5:0] bits_r;
    logic [DATA_W-1:0] data_r, res_r;
    logic trg_r, sck_r;
    logic sdo_s;
    sarrd_sync u_sdo (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sdo & link.sdo_oe), .q_o(sdo_s));
    wire go = wr_i && addr_i == SARRD_REG_CTRL && wdata_i[SARRD_CTRL_GO];
    wire pwr = wr_i && addr_i == SARRD_REG_CTRL
        && (wdata_i[SARRD_CTRL_SHDN] || wdata_i[SARRD_CTRL_WAKE]);
    wire [5:0] nbits = busy_mode_r ? 6'(DATA_W + 1) : 6'(DATA_W);
    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= H_IDLE;
            cnt_r <= 8'h0;
            bits_r <= 6'h0;
            trg_r <= 1'b1;
            sck_r <= 1'b0;
            busy_mode_r <= 1'b0;
            pwr_sck_r <= 1'b0;
            data_r <= '0;
            res_r <= SARRD_RESULT_RST;
            done_r <= 1'b0;
        end else begin
            if (rd_i && addr_i == SARRD_REG_DATA) begin
                done_r <= 1'b0;
            end
            case (st_r)
                H_IDLE: begin
                    // Trigger keeps its level so an idle return starts no conversion
                    sck_r <= 1'b0;
                    if (go) begin
                        busy_mode_r <= wdata_i[SARRD_CTRL_BUSY];
                        cnt_r <= 8'h0;
                        st_r <= H_CONV;
                    end else if (pwr) begin
                        pwr_sck_r <= wdata_i[SARRD_CTRL_SHDN];
                        cnt_r <= 8'h0;
                        st_r <= H_PWR;
                    end
                end
                H_PWR: begin
                    // SCLK set first, trigger dropped later, then restored
                    cnt_r <= cnt_r + 8'h1;
                    sck_r <= pwr_sck_r;
                    // Low long enough that the device has decided before the rise
                    trg_r <= ~(cnt_r >= 8'h4 && cnt_r < 8'hc);
                    if (cnt_r == 8'h14) begin
                        sck_r <= 1'b0;
                        st_r <= H_IDLE;
                    end
                end
                H_CONV: begin
                    // Low, then one clean rise; SCLK and SDI stay still around it
                    cnt_r <= cnt_r + 8'h1;
                    trg_r <= (cnt_r >= 8'h3);
                    if (busy_mode_r && cnt_r == 8'hb) begin
                        trg_r <= 1'b0;
                        st_r <= H_WAITB;
                    end else if (!busy_mode_r && cnt_r == 8'(SARRD_CONV_CYC + 12)) begin
                        trg_r <= 1'b0;
                        cnt_r <= 8'h0;
                        bits_r <= 6'h0;
                        st_r <= H_SHIFT;
                    end
                end
                H_WAITB: begin
                    trg_r <= 1'b0;
                    if (link.sdo_oe && !sdo_s) begin
                        cnt_r <= 8'h0;
                        bits_r <= 6'h0;
                        st_r <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    cnt_r <= cnt_r + 8'h1;
                    if (cnt_r == 8'(SARRD_SCK_HALF_CYC - 1)) begin
                        sck_r <= 1'b1;
                    end else if (cnt_r == 8'(2 * SARRD_SCK_HALF_CYC - 1)) begin
                        // Sample just before fall, after sync latency
                        sck_r <= 1'b0;
                        cnt_r <= 8'h0;
                        bits_r <= bits_r + 6'h1;
                        if (!(busy_mode_r && bits_r == 6'h0)) begin
                            data_r <= {data_r[DATA_W-2:0], sdo_s};
                        end
                        if (bits_r == nbits - 6'h1) begin
                            st_r <= H_IDLE;
                        end
                    end
                end
                default: st_r <= H_IDLE;
            endcase
            if (st_r == H_SHIFT && st_r != H_IDLE && bits_r == nbits) begin
                res_r <= data_r;
            end
            if (st_r == H_IDLE && bits_r == nbits) begin
                res_r <= data_r;
                done_r <= 1'b1;
                bits_r <= 6'h0;
            end
        end
    end
    assign link.conversion_trigger = trg_r;
    assign link.sclk = sck_r;
    assign link.sdi = 1'b1;
    // ==========================================================
    // Register read port
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                SARRD_REG_STAT: rdata_o <= {13'h0000, busy_mode_r, done_r, st_r != H_IDLE};
                SARRD_REG_DATA: rdata_o <= res_r;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// [test/sarrd_assertions.sv]
// Checker on the link between converter end and host end.
// Assumes it sits beside the link interface and samples on the system clock.
`timescale 1ns/10ps
`default_nettype none
module sarrd_assertions
    import sarrd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic conversion_trigger,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic converting_o,
    input wire logic shutdown_o,
    input wire logic chain_mode_o
);
    localparam int CONV_MIN = SARRD_TCONV_MIN_NS / SARRD_CLK_NS;
    localparam int CONV_MAX = SARRD_CONV_CYC + 1;
    logic [5:0] conv_cnt_r;
    logic [5:0] low_cnt_r;
    logic [4:0] fall_cnt_r;
    logic [3:0] since_fall_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================
    // Helper counters, saturating
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) conv_cnt_r <= '0;
        else if (!converting_o) conv_cnt_r <= '0;
        else if (conv_cnt_r != 6'h3f) conv_cnt_r <= conv_cnt_r + 6'h01;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) low_cnt_r <= '0;
        else if (conversion_trigger) low_cnt_r <= '0;
        else if (low_cnt_r != 6'h3f) low_cnt_r <= low_cnt_r + 6'h01;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) fall_cnt_r <= '0;
        else if (!sdo_oe) fall_cnt_r <= '0;
        else if ($fell(sclk) && fall_cnt_r != 5'h1f) fall_cnt_r <= fall_cnt_r + 5'h01;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) since_fall_r <= 4'hf;
        else if ($fell(sclk)) since_fall_r <= '0;
        else if (since_fall_r != 4'hf) since_fall_r <= since_fall_r + 4'h1;
    end
    // ==========================================
    // Properties
    sequence s_idle_rise;
        $rose(conversion_trigger) && !converting_o && !shutdown_o;
    endsequence
    property p_start;
        s_idle_rise ##0 sdi |-> ##[1:6] (converting_o && !sdo_oe);
    endproperty
    property p_mode;
        s_idle_rise |-> ##[1:8] (chain_mode_o == !sdi);
    endproperty
    property p_conv_len;
        $fell(converting_o) |-> (conv_cnt_r >= CONV_MIN) && (conv_cnt_r <= CONV_MAX);
    endproperty
    property p_shdn_in;
        $fell(conversion_trigger) && sclk && !converting_o && !shutdown_o |-> ##[1:8] shutdown_o;
    endproperty
    property p_shdn_out;
        $fell(conversion_trigger) && !sclk && shutdown_o |-> ##[1:8] !shutdown_o;
    endproperty
    property p_busy_low;
        $rose(sdo_oe) && low_cnt_r > 8 |-> !sdo;
    endproperty
    property p_max_falls;
        fall_cnt_r <= 17;
    endproperty
    property p_hold_fall;
        $fell(sclk) && sdo_oe && $past(sdo_oe) |-> $stable(sdo);
    endproperty
    property p_shift_cause;
        sdo_oe && $past(sdo_oe) && $changed(sdo) |-> since_fall_r <= 6;
    endproperty
    a_start: assert property (p_start) else $error("conversion did not start");
    a_mode: assert property (p_mode) else $error("wrong interface mode");
    a_conv_len: assert property (p_conv_len) else $error("conversion length off");
    a_shdn_in: assert property (p_shdn_in) else $error("shutdown not entered");
    a_shdn_out: assert property (p_shdn_out) else $error("shutdown not left");
    a_busy_low: assert property (p_busy_low) else $error("busy bit not low");
    a_max_falls: assert property (p_max_falls) else $error("output held too long");
    a_hold_fall: assert property (p_hold_fall) else $error("data moved at fall");
    a_shift_cause: assert property (p_shift_cause) else $error("data moved uncaused");
endmodule
`default_nettype wire

// [test/sar_adc_serial_readout_test.sv]
// Bench: host end and converter end joined over the link, plus a pin-driven converter.
// Assumes a 10 MHz clock and the host's plain register port.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout_test;
    import sarrd_pkg::*;
    logic clk_i;
    logic rstn_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [15:0] rdata_o;
    logic [15:0] sample_i;
    logic converting_o;
    logic shutdown_o;
    logic chain_mode_o;
    logic busy_en_o;
    logic chain_b;
    logic busy_b;
    int failures = 0;
    int checks_done = 0;
    logic [15:0] pat [4] = '{16'ha5c3, 16'hffff, 16'h0001, 16'h8000};
    sarrd_if link();
    sarrd_if link_b();
    sarrd_dev sarrd_dev_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .sample_i(sample_i),
        .converting_o(converting_o), .shutdown_o(shutdown_o), .chain_mode_o(chain_mode_o),
        .busy_en_o(busy_en_o));
    sarrd_host sarrd_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    // Second converter end, pins driven by the bench to reach chain mode
    sarrd_dev sarrd_dev_inst_b (.clk_i(clk_i), .rstn_i(rstn_i), .link(link_b),
        .sample_i(sample_i), .converting_o(), .shutdown_o(), .chain_mode_o(chain_b),
        .busy_en_o(busy_b));
    sarrd_assertions sarrd_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .conversion_trigger(link.conversion_trigger), .sclk(link.sclk), .sdi(link.sdi),
        .sdo(link.sdo), .sdo_oe(link.sdo_oe), .converting_o(converting_o),
        .shutdown_o(shutdown_o), .chain_mode_o(chain_mode_o));
    // ==========================================
    // Tasks
    task automatic summarize();
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // Done set and busy clear; bounded so a stuck host is reported
    task automatic wait_done();
        logic [15:0] s;
        int n;
        n = 0;
        do begin
            rd_reg(SARRD_REG_STAT, s);
            n++;
        end while (!(s[1] === 1'b1 && s[0] === 1'b0) && n < 400);
        if (n >= 400) begin
            failures++;
            $display("Error at %0t: readout never finished", $time);
        end
    endtask
    // ==========================================
    // Clock, watchdog, tests
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #2000000;
        failures++;
        summarize();
    end
    initial begin
        logic [15:0] d;
        int i;
        rstn_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        sample_i = 16'h0000;
        link_b.conversion_trigger = 1'b1;
        link_b.sclk = 1'b0;
        link_b.sdi = 1'b1;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        wr_reg(SARRD_REG_CTRL, 16'h0004);
        repeat (40) @(posedge clk_i);
        chk({15'h0000, shutdown_o}, 16'h0001);
        wr_reg(SARRD_REG_CTRL, 16'h0008);
        repeat (40) @(posedge clk_i);
        chk({15'h0000, shutdown_o}, 16'h0000);
        // Odd passes use busy mode: an MSB of one exposes a missed flush
        for (i = 0; i < 4; i++) begin
            sample_i <= pat[i];
            wr_reg(SARRD_REG_CTRL, i[0] ? 16'h0003 : 16'h0001);
            wait_done();
            chk({15'h0000, busy_en_o}, {15'h0000, i[0]});
            rd_reg(SARRD_REG_DATA, d);
            chk(d, pat[i]);
        end
        for (i = 0; i < 3; i++) begin
            link_b.sdi <= (i == 2);
            link_b.sclk <= 1'b0;
            repeat (5) @(posedge clk_i);
            link_b.conversion_trigger <= 1'b0;
            repeat (10) @(posedge clk_i);
            link_b.sclk <= i[0];
            repeat (3) @(posedge clk_i);
            link_b.conversion_trigger <= 1'b1;
            repeat (10) @(posedge clk_i);
            chk({15'h0000, chain_b}, {15'h0000, i != 2});
            if (i != 2) chk({15'h0000, busy_b}, {15'h0000, i[0]});
            repeat (30) @(posedge clk_i);
        end
        summarize();
    end
endmodule
`default_nettype wire
